// [rtl/ars_sequencer.sv]
/*
  ars_sequencer: automatic reclosing sequencer with an AHB-Lite register slave.
  Assumes all line inputs come from other logic or pins, asynchronous to clk,
  and a single AHB-Lite master doing single word transfers.
*/
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ars_sequencer
  import ars_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire ars_inputs_t       linesIn,
  output ars_status_t            statusOut
);
  if (TICK_CYCLES < 1)
  begin : gBadTick
    $error("TICK_CYCLES must be at least 1");
  end

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // input synchroniser
  ars_inputs_t syncAReg;
  ars_inputs_t syncBReg;
  ars_inputs_t in;

  // tick divider
  logic [TICK_W-1:0] tickCntReg;
  logic              tick;

  // settings
  logic [CTRL_W-1:0] ctrlReg;
  logic [TIME_W-1:0] timeReg [NUM_TIMES];

  // bus
  logic              wrPendReg;
  logic [ADDR_W-3:0] wrIdxReg;
  logic              rdWaitReg;
  logic [ADDR_W-3:0] rdIdxReg;
  logic [31:0]       hrdataReg;
  logic              accept;
  logic [ADDR_W-3:0] addrIdx;
  logic [31:0]       readWord;
  logic [31:0]       statusWord;

  // sequencer
  ars_state_t        stateReg;
  ars_state_t        stateNext;
  logic [1:0]        shotReg;
  logic [1:0]        shotNext;
  logic              threePhReg;
  logic              threePhNext;
  logic [TIME_W-1:0] timerReg;
  logic [TIME_W-1:0] closeTimerReg;
  logic              closeActiveReg;
  logic              issueClose;
  logic              restart;
  logic              halt;
  logic              srcBreaker;
  logic [2:0]        shotLimit;
  logic [2:0]        shotSel;
  logic [4:0]        deadSel;
  logic              closeDone;
  ars_status_t       statusReg;

  function automatic logic expired(input logic [TIME_W-1:0] cnt, input logic [TIME_W-1:0] lim);
    expired = (cnt >= lim);
  endfunction

  function automatic logic [4:0] deadIndex(input logic [1:0] shot, input logic threePh, input logic special);
    logic [4:0] idx;
    idx = 5'(T_1PH1) + {3'h0, shot};                                       // see RULE_22
    if (threePh)
    begin
      idx = 5'(T_3PH1) + {3'h0, shot};
      if (shot == 2'h0 && special)
      begin
        idx = 5'(T_SPECIAL);                                               // see RULE_20
      end
    end
    deadIndex = idx;
  endfunction

  function automatic logic timeIdx(input logic [ADDR_W-3:0] idx);
    timeIdx = (idx >= (ADDR_W-2)'(IDX_TIME_BASE)) && (idx < (ADDR_W-2)'(IDX_TIME_BASE + NUM_TIMES));
  endfunction

  // every line input passes two flops before it is looked at
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncAReg <= '0;
      syncBReg <= '0;
    end
    else
    begin
      syncAReg <= linesIn;
      syncBReg <= syncAReg;
    end
  end
  assign in = syncBReg;

  // all timing runs on a 10 ms enable so one counter width covers every setting
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tickCntReg <= '0;
    else if (tick)
      tickCntReg <= '0;
    else
      tickCntReg <= tickCntReg + 1'b1;
  end
  assign tick = (tickCntReg == TICK_W'(TICK_CYCLES - 1));

  // ---------------- AHB-Lite slave ----------------
  // writes are zero wait; reads take one wait state so hrdata comes from a flop
  // and also sees a write committed just before it
  assign accept    = hsel && hready && htrans[1];
  assign addrIdx   = haddr[ADDR_W-1:2];
  assign hreadyout = !rdWaitReg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdataReg;

  assign statusWord = {19'h0,
                       statusReg.notReady,
                       closeActiveReg,
                       statusReg.threePhaseUsed,
                       statusReg.dynBlocked,
                       statusReg.inProgress,                               // see RULE_09
                       1'b0, statusReg.shot,
                       4'(stateReg)};

  assign readWord = (rdIdxReg == (ADDR_W-2)'(IDX_CTRL))   ? {27'h0, ctrlReg} :
                    (rdIdxReg == (ADDR_W-2)'(IDX_STATUS)) ? statusWord :
                    timeIdx(rdIdxReg) ? {12'h0, timeReg[5'(rdIdxReg - (ADDR_W-2)'(IDX_TIME_BASE))]} :
                    32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPendReg <= 1'b0;
      wrIdxReg  <= '0;
      rdWaitReg <= 1'b0;
      rdIdxReg  <= '0;
      hrdataReg <= 32'h0000_0000;
    end
    else
    begin
      wrPendReg <= accept && hwrite;
      rdWaitReg <= accept && !hwrite;
      if (accept)
      begin
        wrIdxReg <= addrIdx;
        rdIdxReg <= addrIdx;
      end
      if (rdWaitReg)
        hrdataReg <= readWord;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrlReg <= CTRL_RESET;
      for (int i = 0; i < NUM_TIMES; i++)
        timeReg[i] <= TIME_RESET[i];
    end
    else if (wrPendReg)
    begin
      if (wrIdxReg == (ADDR_W-2)'(IDX_CTRL))
        ctrlReg <= hwdata[CTRL_W-1:0];
      else if (timeIdx(wrIdxReg))
        timeReg[5'(wrIdxReg - (ADDR_W-2)'(IDX_TIME_BASE))] <= hwdata[TIME_W-1:0];
    end
  end

  // ---------------- sequencer ----------------
  assign shotSel    = ctrlReg[CTRL_SHOTS_LSB +: CTRL_SHOTS_W];
  assign shotLimit  = (shotSel > 3'(MAX_SHOTS)) ? 3'(MAX_SHOTS) : shotSel;  // see RULE_11
  assign srcBreaker = ctrlReg[CTRL_SRC_BIT];                                // see RULE_02
  assign halt       = !ctrlReg[CTRL_OP_BIT]                                 // see RULE_12
                      || in.blockIn                                         // see RULE_06
                      || in.deviceBlockIn                                   // see RULE_13
                      || (shotLimit == 3'h0);                               // see RULE_11
  assign deadSel    = deadIndex(shotReg, threePhReg, in.specialDeadTimeSelectIn);   // see RULE_19
  assign closeDone  = !closeActiveReg;

  always_comb
  begin
    stateNext   = stateReg;
    shotNext    = shotReg;
    threePhNext = threePhReg;
    restart     = 1'b0;
    issueClose  = 1'b0;
    if (in.manualCloseIn)
    begin
      // held manual close keeps restarting the blocking time
      stateNext   = ST_MANBLK;                                              // see RULE_10
      restart     = 1'b1;
      shotNext    = 2'h0;
      threePhNext = 1'b0;
    end
    else if (halt && stateReg != ST_MANBLK)
    begin
      stateNext   = ST_IDLE;                                                // see RULE_06
      shotNext    = 2'h0;
      threePhNext = 1'b0;
    end
    else
    begin
      case (stateReg)
        ST_IDLE:
        begin
          shotNext    = 2'h0;
          threePhNext = 1'b0;
          if (in.tripIn)
            stateNext = ST_TRIP;
          else if (in.protectionPickupIn)
            stateNext = ST_ACTION;                                          // see RULE_07
        end
        ST_ACTION:
        begin
          if (in.tripIn)
            stateNext = ST_TRIP;
          else if (expired(timerReg, timeReg[T_ACTION]))
            stateNext = ST_DYNBLK;                                          // see RULE_07
        end
        ST_TRIP:
        begin
          // trip type is gathered while the trip stands; never cleared mid-sequence
          threePhNext = threePhReg || in.threePhaseTripIn;                  // see RULE_23
          if (srcBreaker ? in.breakerOpenIn : !in.tripIn)
            stateNext = ST_DELAY;                                           // see RULE_02
          else if (expired(timerReg, timeReg[T_MAXST]))
            stateNext = ST_DYNBLK;                                          // see RULE_15 see RULE_16 see RULE_17
        end
        ST_DELAY:
        begin
          if (!in.deadTimeDelayIn || expired(timerReg, timeReg[T_DTDEL]))
            stateNext = ST_DEAD;                                            // see RULE_18
        end
        ST_DEAD:
        begin
          if (expired(timerReg, timeReg[deadSel]))
            stateNext = ST_CBWAIT;                                          // see RULE_01 see RULE_03
        end
        ST_CBWAIT:
        begin
          if (in.breakerReadyIn)
          begin
            stateNext  = ST_RECLAIM;                                        // see RULE_03
            issueClose = 1'b1;
          end
          else if (expired(timerReg, timeReg[T_CBSUP]))
            stateNext = ST_DYNBLK;                                          // see RULE_08
        end
        ST_RECLAIM:
        begin
          if (in.protectionPickupIn || in.tripIn)
          begin
            if (3'(shotReg) + 3'h1 < shotLimit)
            begin
              shotNext  = shotReg + 2'h1;                                   // see RULE_04
              stateNext = in.tripIn ? ST_TRIP : ST_ACTION;
            end
            else
              stateNext = ST_DYNBLK;
          end
          else if (expired(timerReg, timeReg[T_RECLAIM]) && closeDone)
          begin
            // reclaim is stretched until the close pulse has ended
            stateNext   = ST_IDLE;                                          // see RULE_05
            shotNext    = 2'h0;
            threePhNext = 1'b0;
          end
        end
        ST_DYNBLK:
        begin
          if (expired(timerReg, timeReg[T_DYNBLK]))
          begin
            stateNext   = ST_IDLE;                                          // see RULE_24
            shotNext    = 2'h0;
            threePhNext = 1'b0;
          end
        end
        ST_MANBLK:
        begin
          if (expired(timerReg, timeReg[T_MANBLK]))
            stateNext = ST_IDLE;                                            // see RULE_10
        end
        default:
        begin
          stateNext = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateReg   <= ST_IDLE;
      shotReg    <= 2'h0;
      threePhReg <= 1'b0;
    end
    else
    begin
      stateReg   <= stateNext;
      shotReg    <= shotNext;
      threePhReg <= threePhNext;
    end
  end

  // one shared state timer, saturating so a long wait cannot wrap to a false expiry
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      timerReg <= '0;
    else if (restart || stateNext != stateReg)
      timerReg <= '0;
    else if (tick && timerReg != '1)
      timerReg <= timerReg + 1'b1;
  end

  // close pulse timer; the pulse starts on the edge the sequencer leaves breaker wait
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      closeActiveReg <= 1'b0;
      closeTimerReg  <= '0;
    end
    else if (stateNext == ST_DYNBLK || stateNext == ST_IDLE || stateNext == ST_MANBLK)
    begin
      closeActiveReg <= 1'b0;                                               // see RULE_24
      closeTimerReg  <= '0;
    end
    else if (issueClose)
    begin
      closeActiveReg <= 1'b1;                                               // see RULE_03
      closeTimerReg  <= '0;
    end
    else if (closeActiveReg)
    begin
      if (expired(closeTimerReg, timeReg[T_CLOSE]))
        closeActiveReg <= 1'b0;                                             // see RULE_21
      else if (tick)
        closeTimerReg <= closeTimerReg + 1'b1;
    end
  end

  // status flops follow the next state so they line up with the state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      statusReg <= '0;
    else
    begin
      statusReg.inProgress     <= (stateNext == ST_TRIP) || (stateNext == ST_DELAY) ||
                                  (stateNext == ST_DEAD) || (stateNext == ST_CBWAIT) ||
                                  (stateNext == ST_RECLAIM);                // see RULE_09
      statusReg.dynBlocked     <= (stateNext == ST_DYNBLK);
      statusReg.notReady       <= (stateNext == ST_MANBLK);
      statusReg.threePhaseUsed <= threePhNext;
      statusReg.shot           <= (stateNext == ST_IDLE) ? 3'h0 : 3'(shotNext) + 3'h1;
      statusReg.closeCmd       <= 1'b0;
    end
  end

  always_comb
  begin
    statusOut          = statusReg;
    statusOut.closeCmd = closeActiveReg;
  end

  // the far side keeps breaker open high while any pole is open; only its level is used here
  // see RULE_14
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule // ars_sequencer
`default_nettype wire

// [pkg/ars_pkg.sv]
/*
  ars_pkg: constants, register map, reset values, carrier structs and state type
  for the automatic reclosing sequencer.
  Assumes a 10 MHz clock and settings held in ticks of 10 ms.
*/
// How it works
// RULE_01: up to four shots, each with own single- and multi-phase dead time.
// RULE_02: start source picks trip fall or breaker open to begin dead time.
// RULE_03: dead time expiry issues the close command with no external request.
// RULE_04: reclaim starts at close; pickup during reclaim moves to next shot.
// RULE_05: no pickup before reclaim expiry returns to idle at shot one.
// RULE_06: own block input stops any start and aborts a running sequence.
// RULE_07: pickup starts action timer; no trip before expiry gives dynamic block.
// RULE_08: wait breaker ready up to supervision time, else abort then dynamic block.
// RULE_09: status outputs include an in-progress flag for external logic.
// RULE_10: manual close keeps the sequencer disabled for the blocking time.
// RULE_11: shot count selects none, 1, 1-2, 1-3 or 1-4 shots.
// RULE_12: operation enable switches the whole sequencer on or off.
// RULE_13: device-wide block acts like the own block input.
// RULE_14: outside logic asserts breaker open whenever any pole is open.
// RULE_15: trip assertion starts a timer compared against max start-signal time.
// RULE_16: trip-reset mode: trip held beyond max start time gives dynamic block.
// RULE_17: breaker-open mode: no breaker open during that timer gives dynamic block.
// RULE_18: dead-time delay input holds off dead time, at most the max delay.
// RULE_19: eight dead times, chosen by current shot and trip type.
// RULE_20: first three-phase shot uses special dead time when its select is high.
// RULE_21: close command is a pulse lasting the close pulse time.
// RULE_22: without three-phase trip the single-phase dead times apply.
// RULE_23: once three-phase dead time is used, later shots keep using it.
// RULE_24: dynamic block suppresses closing until its timer ends, then idle.
package ars_pkg;
  localparam int CLK_FREQ_HZ     = 10_000_000;
  localparam int TICK_TIME_MS    = 10;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int TIME_W          = 20;
  localparam int MAX_SHOTS       = 4;
  localparam int NUM_TIMES       = 17;
  localparam int ADDR_W          = 8;

  // time setting indices, each setting in 10 ms ticks
  localparam int T_RECLAIM = 0;
  localparam int T_CLOSE   = 1;
  localparam int T_DYNBLK  = 2;
  localparam int T_MANBLK  = 3;
  localparam int T_ACTION  = 4;
  localparam int T_MAXST   = 5;
  localparam int T_DTDEL   = 6;
  localparam int T_CBSUP   = 7;
  localparam int T_1PH1    = 8;
  localparam int T_3PH1    = 12;
  localparam int T_SPECIAL = 16;

  // word indices (haddr bits above 1:0): ctrl, status, then one word per time setting
  localparam int IDX_CTRL      = 0;
  localparam int IDX_STATUS    = 1;
  localparam int IDX_TIME_BASE = 2;

  localparam int CTRL_OP_BIT    = 0;
  localparam int CTRL_SHOTS_LSB = 1;
  localparam int CTRL_SHOTS_W   = 3;
  localparam int CTRL_SRC_BIT   = 4;
  localparam int CTRL_W         = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h03;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_SHOT_LSB  = 4;
  localparam int ST_RUN_BIT   = 8;
  localparam int ST_DYN_BIT   = 9;
  localparam int ST_3PH_BIT   = 10;
  localparam int ST_CLOSE_BIT = 11;
  localparam int ST_NRDY_BIT  = 12;

  localparam logic [TIME_W-1:0] TIME_RESET [NUM_TIMES] = '{
    20'h000C8, 20'h0000A, 20'h00096, 20'h00064, 20'h00064, 20'h00064, 20'h0012C, 20'h00064,
    20'h00064, 20'h000C8, 20'h0012C, 20'h00190,
    20'h00032, 20'h0003C, 20'h00046, 20'h00050,
    20'h00064};

  typedef struct packed {
    logic tripIn;
    logic threePhaseTripIn;
    logic breakerOpenIn;
    logic breakerReadyIn;
    logic blockIn;
    logic deviceBlockIn;
    logic manualCloseIn;
    logic deadTimeDelayIn;
    logic specialDeadTimeSelectIn;
    logic protectionPickupIn;
  } ars_inputs_t;

  typedef struct packed {
    logic       closeCmd;
    logic       inProgress;
    logic       dynBlocked;
    logic       notReady;
    logic       threePhaseUsed;
    logic [2:0] shot;
  } ars_status_t;

  typedef enum {
    ST_IDLE, ST_ACTION, ST_TRIP, ST_DELAY, ST_DEAD, ST_CBWAIT, ST_RECLAIM, ST_DYNBLK, ST_MANBLK
  } ars_state_t;
endpackage

// [dv/ars_line_model.sv]
/*
  ars_line_model: breaker side of the sequencer, open flag and ready flag.
  assumes the bench asks for a pole opening by openReq and sets readiness by readyEn.
*/
`timescale 1ns/1ps
`default_nettype none
module ars_line_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic openReq,
  input  wire logic readyEn,
  input  wire logic closeCmd,
  output logic      breakerOpenIn,
  output logic      breakerReadyIn
);
  logic [1:0] closeDly_reg;

  // poles take two cycles to move after a close, so the open flag lingers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      breakerOpenIn <= 1'b0;
      closeDly_reg  <= 2'h0;
    end
    else
    begin
      closeDly_reg <= {closeDly_reg[0], closeCmd};
      if (openReq)
        breakerOpenIn <= 1'b1;
      else if (closeDly_reg[1])
        breakerOpenIn <= 1'b0;
    end
  end

  assign breakerReadyIn = readyEn;
endmodule // ars_line_model
`default_nettype wire

// [dv/ars_sequencer_asserts.sv]
/*
  ars_sequencer_asserts: port-level checks for the reclosing sequencer.
  assumes it is bound into ars_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ars_sequencer_asserts
  import ars_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire ars_inputs_t linesIn,
  input wire ars_status_t statusOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_close_in_run;
    $rose(statusOut.closeCmd) |-> statusOut.inProgress && !statusOut.dynBlocked;
  endproperty
  a_close_in_run: assert property (p_close_in_run) else $error("close outside a sequence");

  // one tick is at least four cycles, so a two-tick pulse never ends sooner
  property p_close_width;
    $rose(statusOut.closeCmd) |=> statusOut.closeCmd [*3];
  endproperty
  a_close_width: assert property (p_close_width) else $error("close pulse too short");

  property p_block;
    linesIn.blockIn [*5] |-> !statusOut.inProgress && !statusOut.closeCmd;
  endproperty
  a_block: assert property (p_block) else $error("running while blocked");

  property p_dev_block;
    linesIn.deviceBlockIn [*5] |-> !statusOut.inProgress && !statusOut.closeCmd;
  endproperty
  a_dev_block: assert property (p_dev_block) else $error("running while device blocked");

  property p_manual;
    linesIn.manualCloseIn [*4] |=> statusOut.notReady && !statusOut.closeCmd;
  endproperty
  a_manual: assert property (p_manual) else $error("not disabled after manual close");

  property p_shot_max;
    statusOut.shot <= 3'h4;
  endproperty
  a_shot_max: assert property (p_shot_max) else $error("shot beyond four");

  property p_shot_step;
    $changed(statusOut.shot) && statusOut.shot != 3'h0 |-> statusOut.shot == $past(statusOut.shot) + 3'h1;
  endproperty
  a_shot_step: assert property (p_shot_step) else $error("shot skipped");

  property p_dyn_no_close;
    statusOut.dynBlocked |-> !$rose(statusOut.closeCmd);
  endproperty
  a_dyn_no_close: assert property (p_dyn_no_close) else $error("close while dynamically blocked");
endmodule // ars_sequencer_asserts

bind ars_sequencer ars_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .linesIn(linesIn), .statusOut(statusOut)
);
`default_nettype wire

// [dv/ars_sequencer_tb.sv]
/*
  ars_sequencer_tb: self-checking bench for the reclosing sequencer.
  assumes the design, its checker and the breaker model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module ars_sequencer_tb
  import ars_pkg::*;
;
  localparam int T  = 4;
  localparam int CL = 7;
  localparam int RN = 6;
  localparam int DY = 5;
  localparam int NR = 4;
  localparam int SET [NUM_TIMES] = '{20, 2, 10, 10, 10, 10, 5, 10, 2, 6, 10, 14, 18, 22, 26, 30, 34};
  logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, openReq, readyEn, bOpen, bReady;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  ars_inputs_t drv, lines;
  ars_status_t statusOut;
  int          mismatches, checked;

  always_comb
  begin
    lines = drv;
    lines.breakerOpenIn = bOpen;
    lines.breakerReadyIn = bReady;
  end

  ars_sequencer #(.TICK_CYCLES(T)) u_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .linesIn(lines), .statusOut(statusOut)
  );

  ars_line_model u_line (
    .clk(clk), .rst_b(rst_b), .openReq(openReq), .readyEn(readyEn), .closeCmd(statusOut.closeCmd),
    .breakerOpenIn(bOpen), .breakerReadyIn(bReady)
  );

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", w, e, g);
    end
  endtask

  task automatic rng(input string w, input int lo, input int hi, input int v);
    checked++;
    if (v < lo || v > hi)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", w, lo, hi, v);
    end
  endtask

  // ready is read at the falling edge, where it already shows what the next rising edge samples
  task automatic bwait();
    logic r;
    do
    begin
      @(negedge clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end
    while (r !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    bwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bwait();
  endtask

  task automatic waitb(input int b, input logic v, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (statusOut[b] !== v && n < lim);
  endtask

  task automatic shot(input logic tp, input logic sp, input int d, input int s);
    int n;
    @(posedge clk);
    drv.threePhaseTripIn <= tp;
    drv.specialDeadTimeSelectIn <= sp;
    drv.tripIn <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("shot", s, statusOut.shot);
    chk("running", 1, statusOut.inProgress);
    @(posedge clk);
    drv.tripIn <= 1'b0;
    drv.threePhaseTripIn <= 1'b0;
    waitb(CL, 1, 600, n);
    rng("dead time", (d - 1) * T - 2, (d + 1) * T + 6, n);
    waitb(CL, 0, 100, n);
    rng("close pulse", (SET[T_CLOSE] - 1) * T, (SET[T_CLOSE] + 1) * T, n);
  endtask

  task automatic idle();
    int n;
    waitb(RN, 0, 600, n);
    rng("reclaim", (SET[T_RECLAIM] - 3) * T, (SET[T_RECLAIM] + 1) * T + 6, n);
    chk("idle shot", 0, statusOut.shot);
  endtask

  task automatic dynchk(input int t);
    int n;
    waitb(DY, 1, 600, n);
    rng("block entry", (t - 1) * T, (t + 1) * T + 6, n);
    @(posedge clk);
    drv <= '0;
    waitb(DY, 0, 600, n);
    rng("block time", (SET[T_DYNBLK] - 1) * T, (SET[T_DYNBLK] + 1) * T + 6, n);
    chk("block shot", 0, statusOut.shot);
  endtask

  task automatic t_regs();
    ahb(0, 0, 0);
    chk("control reset", CTRL_RESET, rd);
    ahb(0, 8, 0);
    chk("reclaim reset", TIME_RESET[T_RECLAIM], rd);
    for (int i = 0; i < NUM_TIMES; i++)
      ahb(1, 8 + 4 * i, SET[i]);
    ahb(0, 8 + 4 * T_SPECIAL, 0);
    chk("special time", SET[T_SPECIAL], rd);
    ahb(1, 32'h0000004C, 32'h00005A5A);
    ahb(0, 32'h0000004C, 0);
    chk("unmapped", 0, rd);
    chk("response", 0, hresp);
  endtask

  task automatic t_single();
    ahb(1, 0, 9);
    for (int s = 1; s <= MAX_SHOTS; s++)
      shot(0, 0, SET[T_1PH1 + s - 1], s);
    idle();
  endtask

  task automatic t_faults();
    @(posedge clk);
    drv.protectionPickupIn <= 1'b1;
    dynchk(SET[T_ACTION]);
    @(posedge clk);
    drv.tripIn <= 1'b1;
    dynchk(SET[T_MAXST]);
    @(posedge clk);
    readyEn <= 1'b0;
    drv.tripIn <= 1'b1;
    repeat (6) @(posedge clk);
    drv.tripIn <= 1'b0;
    dynchk(SET[T_1PH1] + SET[T_CBSUP]);
    @(posedge clk);
    readyEn <= 1'b1;
  endtask

  task automatic t_delay();
    @(posedge clk);
    drv.deadTimeDelayIn <= 1'b1;
    shot(0, 0, SET[T_DTDEL] + SET[T_1PH1], 1);
    idle();
  endtask

  task automatic t_cbopen();
    int n;
    ahb(1, 0, 32'h00000019);
    @(posedge clk);
    drv.tripIn <= 1'b1;
    drv.deadTimeDelayIn <= 1'b0;
    repeat (8) @(posedge clk);
    openReq <= 1'b1;
    @(posedge clk);
    openReq <= 1'b0;
    repeat (4) @(posedge clk);
    drv.tripIn <= 1'b0;
    waitb(CL, 1, 600, n);
    rng("open start", SET[T_1PH1] * T - 2, SET[T_1PH1] * T + T - 1, n);
    idle();
    @(posedge clk);
    drv.tripIn <= 1'b1;
    dynchk(SET[T_MAXST]);
  endtask

  task automatic t_three();
    ahb(1, 0, 5);
    shot(1, 0, SET[T_3PH1], 1);
    chk("three-phase used", 1, statusOut.threePhaseUsed);
    shot(0, 0, SET[T_3PH1 + 1], 2);
    idle();
    ahb(1, 0, 3);
    shot(1, 1, SET[T_SPECIAL], 1);
    @(posedge clk);
    drv.tripIn <= 1'b1;
    dynchk(0);
  endtask

  // block lines arrive with the trip fall, so they hit a started sequence
  task automatic t_refuse();
    int n;
    for (int k = 0; k < 4; k++)
    begin
      ahb(1, 0, k == 2 ? 8 : (k == 3 ? 1 : 9));
      @(posedge clk);
      drv.tripIn <= 1'b1;
      repeat (6) @(posedge clk);
      drv.tripIn <= 1'b0;
      drv.blockIn <= (k == 0);
      drv.deviceBlockIn <= (k == 1);
      waitb(CL, 1, 60, n);
      rng("refused close", 60, 60, n);
      chk("refused run", 0, statusOut.inProgress);
      @(posedge clk);
      drv <= '0;
    end
  endtask

  task automatic t_manual();
    int n;
    ahb(1, 0, 9);
    @(posedge clk);
    drv.manualCloseIn <= 1'b1;
    repeat (4) @(posedge clk);
    drv.manualCloseIn <= 1'b0;
    ahb(0, 4, 0);
    chk("status not ready", 1, rd[ST_NRDY_BIT]);
    waitb(NR, 0, 600, n);
    rng("manual block", (SET[T_MANBLK] - 1) * T, (SET[T_MANBLK] + 1) * T + 6, n);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #2_000_000;
    mismatches++;
    conclude();
  end

  initial
  begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    drv = '0;
    openReq = 1'b0;
    readyEn = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_single();
    t_faults();
    t_delay();
    t_cbopen();
    t_three();
    t_refuse();
    t_manual();
    conclude();
  end
endmodule // ars_sequencer_tb
`default_nettype wire
